// [dv/flash_program_mode_control_monitor.sv]
// Checker for the flash programming-mode control block
`timescale 1ns/100ps
module flash_prog_monitor
  import flash_prog_pkg::*;
#(
  parameter logic [15:0] SYS_VECTOR = 16'h1000 // Arbitrary value
) (
  // Clock and reset
  input logic                aclk,
  input logic                aresetn,
  // Pins and option byte
  input logic                reset_pin_n,
  input logic [7:0]          option_byte,
  // Flash array port
  input logic                fl_ack,
  input logic                fl_req,
  input logic [1:0]          fl_cmd,
  input logic [FLASH_AW-1:0] fl_addr,
  input logic [7:0]          fl_wdata,
  // Boot and loader
  input logic [15:0]         boot_vector,
  input logic                ram_wr_en,
  input logic                exec_from_ram,
  input logic                in_circuit_comm_mode,
  input logic                in_app_prog_mode
);
  // ==========
  // Flash engine
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hold;
    fl_req && !fl_ack |=> fl_req && $stable({fl_cmd, fl_addr, fl_wdata});
  endproperty
  a_hold: assert property (p_hold)
    else $error("flash request changed before ack");
  property p_drop;
    fl_req && fl_ack |=> !fl_req;
  endproperty
  a_drop: assert property (p_drop)
    else $error("flash request not dropped after ack");
  // Application code may touch sector 1 only, never the option row
  property p_app_opt;
    in_app_prog_mode && fl_req |-> !fl_cmd[1];
  endproperty
  a_app_opt: assert property (p_app_opt)
    else $error("option row changed in application mode");
  property p_app_s0;
    in_app_prog_mode && fl_req |->
      fl_addr >= (SECTOR0_MIN << option_byte[OPT_S0 +: 2]);
  endproperty
  a_app_s0: assert property (p_app_s0)
    else $error("sector 0 changed in application mode");
  property p_lock;
    option_byte[OPT_LOCK] && !fl_req |=> !fl_req;
  endproperty
  a_lock: assert property (p_lock)
    else $error("flash request while locked");
  // ==========
  // Link session; the pin is synchronised, hence the slack
  property p_boot;
    $rose(in_circuit_comm_mode) |-> ##[0:2] boot_vector == SYS_VECTOR;
  endproperty
  a_boot: assert property (p_boot)
    else $error("system vector not selected");
  property p_exit;
    $fell(reset_pin_n) |-> ##[1:6] !in_circuit_comm_mode && !exec_from_ram;
  endproperty
  a_exit: assert property (p_exit)
    else $error("session kept while reset pin low");
  property p_ram;
    ram_wr_en |-> in_circuit_comm_mode ##1 !ram_wr_en;
  endproperty
  a_ram: assert property (p_ram)
    else $error("bad ram write pulse");
  property p_exec;
    $rose(exec_from_ram) |-> in_circuit_comm_mode;
  endproperty
  a_exec: assert property (p_exec)
    else $error("ram execution outside session");
  c_erase: cover property (fl_req && fl_ack && fl_cmd == FL_ERASE);
  c_ram: cover property (ram_wr_en);
  c_exec: cover property ($rose(exec_from_ram));
endmodule
bind flash_program_mode_control flash_prog_monitor #(
  .SYS_VECTOR(SYS_VECTOR)
) u_monitor (.*);

// [dv/flash_program_mode_control_test.sv]
// Self-checking bench for the flash programming-mode control block
`timescale 1ns/100ps
module flash_program_mode_control_test;
  import flash_prog_pkg::*;
  localparam logic [15:0] SYS_V = 16'h1000; // Arbitrary value
  localparam logic [15:0] APP_V = 16'hfffe; // Arbitrary value
  localparam logic [7:0]  KEY   = 8'ha5;    // Arbitrary value
  logic aclk, aresetn, prog_link_clock, prog_link_data, reset_pin_n;
  logic tool_socket, fl_ack, fl_req, ram_wr_en, exec_from_ram;
  logic in_circuit_comm_mode, in_circuit_prog_mode, in_app_prog_mode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [AXI_AW-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, v;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, fl_cmd;
  logic [FLASH_AW-1:0] fl_addr;
  logic [7:0]          option_byte, fl_wdata, ram_wr_addr, ram_wr_data;
  logic [15:0]         boot_vector, seed, ar, re;
  logic [22:0]         fe;
  logic [22:0]         fq[$];
  logic [15:0]         rq[$];
  logic [12:0] bad_addr[4] = '{13'h01ff, 13'h0300, 13'h0100, 13'h0300};
  logic [7:0]  bad_ctrl[4] = '{8'h01, 8'h09, 8'h05, 8'h07};
  int          miscompares, comparisons;
  // ==========
  // Clock, design and tool
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  flash_program_mode_control #(
    .SYS_VECTOR(SYS_V), .APP_VECTOR(APP_V), .ENTRY_KEY(KEY)
  ) dut (.*);
  prog_tool_model tool (
    .link_clock(prog_link_clock),
    .link_data (prog_link_data),
    .reset_n   (reset_pin_n)
  );
  // ==========
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Erases carry no data and option operations no array address
  function automatic logic [22:0] msk(input logic [22:0] x);
    return {x[22:21], x[20:8] & {13{~x[22]}}, x[7:0] & {8{~x[21]}}};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] i, input logic [1:0] r,
                    output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", r, s_axi_rresp);
  endtask
  // Start an operation, wait out busy, check refusal, clear the flag
  task automatic run(input logic [7:0] c, input logic r);
    logic [31:0] d;
    wr(IDX_CTRL, c, RESP_OKAY);
    do begin
      rd(IDX_CTRL, RESP_OKAY, d);
    end while (d[CTRL_BUSY] !== 1'b0);
    chk("refused", r, d[CTRL_REFUSED]);
    if (r) wr(IDX_CTRL, 32'h0000_0020, RESP_OKAY);
    chk("pending", 0, fq.size());
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // Flash array with random ack stalls; results checked in issue order
  always @(posedge aclk) begin
    ar <= lfsr(ar);
    fl_ack <= fl_req && !fl_ack && ar[0] && aresetn;
    if ((fl_req && fl_ack) === 1'b1) begin
      fe = fq.size() ? fq.pop_front() : 'x;
      chk("flash", msk(fe), msk({fl_cmd, fl_addr, fl_wdata}));
    end
    if (ram_wr_en === 1'b1) begin
      re = rq.size() ? rq.pop_front() : 'x;
      chk("ram", re, {ram_wr_addr, ram_wr_data});
    end
  end
  // Watchdog: whole run needs well under 25k cycles
  initial begin
    #1000000;
    miscompares++;
    complete_run();
  end
  // ==========
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fl_ack, tool_socket} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, option_byte} = '0;
    s_axi_wstrb = 4'hf;
    seed = 16'hd79e;
    ar = 16'hd79e;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, RESP_OKAY, v);
    chk("ctrl", CTRL_RESET, v);
    rd(IDX_STATUS, RESP_OKAY, v);
    chk("mode", MODE_IN_APP, v[1:0]);
    chk("app", 1, in_app_prog_mode);
    chk("prog", 0, in_circuit_prog_mode);
    rd(8'h00, RESP_SLVERR, v);
    wr(8'h00, 32'h0000_00ff, RESP_SLVERR);
    wr(IDX_PAGE, 8'h5a, RESP_OKAY);
    wr(IDX_ADDR, 13'h0300, RESP_OKAY);
    fq.push_back({FL_PROG, 13'h0300, 8'h5a});
    run(8'h01, 1'b0);
    // Full page ending on the last array byte
    wr(IDX_COUNT, 8'h20, RESP_OKAY);
    wr(IDX_ADDR, 13'h1fe0, RESP_OKAY);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      seed = lfsr(seed);
      wr(8'(IDX_PAGE + i), seed[7:0], RESP_OKAY);
      fq.push_back({FL_PROG, 13'(13'h1fe0 + i), seed[7:0]});
    end
    run(8'h03, 1'b0);
    wr(IDX_ADDR, 13'h0400, RESP_OKAY);
    fq.push_back({FL_ERASE, 13'h0400, 8'h00});
    run(8'h05, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_ADDR, bad_addr[i], RESP_OKAY);
      run(bad_ctrl[i], 1'b1);
    end
    option_byte <= 8'h01;
    run(8'h01, 1'b1);
    option_byte <= 8'h80;
    run(8'h01, 1'b1);
    option_byte <= 8'h40;
    // Wrong key, then the real entry and a two-byte download
    tool.enter(8'h5a);
    repeat (8) @(posedge aclk);
    chk("comm", 0, in_circuit_comm_mode);
    chk("boot", APP_V, boot_vector);
    tool.enter(KEY);
    repeat (8) @(posedge aclk);
    chk("comm", 1, in_circuit_comm_mode);
    chk("boot", SYS_V, boot_vector);
    tool.send(8'h02);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      rq.push_back({8'(i), seed[7:0]});
      tool.send(seed[7:0]);
    end
    repeat (8) @(posedge aclk);
    chk("exec", 1, exec_from_ram);
    chk("ramq", 0, rq.size());
    rd(IDX_STATUS, RESP_OKAY, v);
    chk("mode", MODE_IN_CIRCUIT, v[1:0]);
    chk("prog", 1, in_circuit_prog_mode);
    chk("app", 0, in_app_prog_mode);
    wr(IDX_PAGE, 8'hc3, RESP_OKAY);
    wr(IDX_ADDR, 13'h0010, RESP_OKAY);
    fq.push_back({FL_PROG, 13'h0010, 8'hc3});
    run(8'h01, 1'b0);
    fq.push_back({FL_ERASE, 13'h0000, 8'h00});
    fq.push_back({FL_ERASE, 13'h0200, 8'h00});
    fq.push_back({FL_ERASE_OPT, 13'h0000, 8'h00});
    run(8'h0d, 1'b0);
    tool_socket <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(IDX_STATUS, RESP_OKAY, v);
    chk("mode", MODE_TOOL, v[1:0]);
    chk("prog", 0, in_circuit_prog_mode);
    chk("app", 0, in_app_prog_mode);
    wr(IDX_PAGE, 8'h40, RESP_OKAY);
    fq.push_back({FL_PROG_OPT, 13'h0000, 8'h40});
    run(8'h09, 1'b0);
    complete_run();
  end
endmodule

// [dv/prog_tool_model.sv]
// Programming tool model: link clock, link data and device reset pin
`timescale 1ns/100ps
module prog_tool_model (
  // Pins driven by the tool
  output logic link_clock,
  output logic link_data,
  output logic reset_n
);
  // ==========
  // Idle pins: clock stands low between frames
  initial begin
    link_clock = 1'b0;
    link_data = 1'b1;
    reset_n = 1'b1;
  end
  // One byte, MSB first, 320 ns per bit
  task automatic send(input logic [7:0] b);
    #5; // Keep pin changes clear of the sampling clock edge
    for (int i = 7; i >= 0; i--) begin
      link_data = b[i];
      #80 link_clock = 1'b1;
      #160 link_clock = 1'b0;
      #80;
    end
    link_data = ~b[0]; // Released line must not look held
  endtask
  // Key shifted in while the reset pin is held low
  task automatic enter(input logic [7:0] key);
    #5 reset_n = 1'b0;
    #400 send(key);
    #400 reset_n = 1'b1;
  endtask
endmodule

// [verilog/flash_prog_pkg.sv]
// Constants and types shared by the flash programming-mode control block
package flash_prog_pkg;
  // ===================================================================
  // Register map: indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL   = 8'h72;
  localparam logic [7:0] IDX_ADDR   = 8'h73;
  localparam logic [7:0] IDX_COUNT  = 8'h74;
  localparam logic [7:0] IDX_STATUS = 8'h75;
  localparam logic [7:0] IDX_PAGE   = 8'h80;
  localparam int         AXI_AW     = 10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ===================================================================
  // Control register fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_OP      = 1;
  localparam int CTRL_OPT     = 3;
  localparam int CTRL_BUSY    = 4;
  localparam int CTRL_REFUSED = 5;
  localparam logic [1:0] OP_BYTE  = 2'h0;
  localparam logic [1:0] OP_PAGE  = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  // ===================================================================
  // Flash array commands and option byte fields
  localparam logic [1:0] FL_PROG      = 2'h0;
  localparam logic [1:0] FL_ERASE     = 2'h1;
  localparam logic [1:0] FL_PROG_OPT  = 2'h2;
  localparam logic [1:0] FL_ERASE_OPT = 2'h3;
  localparam int OPT_LOCK = 7;
  localparam int OPT_RDP  = 6;
  localparam int OPT_S0   = 0;
  // ===================================================================
  // Array geometry and bus response codes
  localparam int              PAGE_BYTES  = 32;
  localparam int              FLASH_AW    = 13;
  localparam logic [12:0]     SECTOR0_MIN = 13'h0200;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;
  // ===================================================================
  // Modes and state machines
  typedef enum logic [1:0] {
    MODE_TOOL = 2'h0, MODE_IN_CIRCUIT = 2'h1, MODE_IN_APP = 2'h2
  } mode_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_CLEAR0 = 4'h2, S_CLEAR1 = 4'h4, S_OP = 4'h8
  } eng_e;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_LEN = 4'h2, RX_DATA = 4'h4, RX_RUN = 4'h8
  } rx_e;
endpackage

// [verilog/flash_program_mode_control.sv]
// Flash programming-mode control: bus registers, engine, link entry
`timescale 1ns/100ps
module flash_program_mode_control #(
  parameter logic [15:0] SYS_VECTOR = 16'h1000, // Arbitrary value
  parameter logic [15:0] APP_VECTOR = 16'hFFFE, // Arbitrary value
  parameter logic [7:0]  ENTRY_KEY  = 8'hA5,    // Arbitrary value
  parameter int          PAGE_BYTES = flash_prog_pkg::PAGE_BYTES
) (
  // Clock and reset
  input  logic                              aclk,
  input  logic                              aresetn,
  // AXI4-Lite write channels
  input  logic [flash_prog_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  logic                              s_axi_awvalid,
  output logic                              s_axi_awready,
  input  logic [31:0]                       s_axi_wdata,
  input  logic [3:0]                        s_axi_wstrb,
  input  logic                              s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  logic                              s_axi_bready,
  // AXI4-Lite read channels
  input  logic [flash_prog_pkg::AXI_AW-1:0] s_axi_araddr,
  input  logic                              s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  logic                              s_axi_rready,
  // Programming link, device reset pin and tool strap
  input  logic                              prog_link_clock,
  input  logic                              prog_link_data,
  input  logic                              reset_pin_n,
  input  logic                              tool_socket,
  // Option byte as read from the option row
  input  logic [7:0]                        option_byte,
  // Flash array port
  input  logic                              fl_ack,
  output logic                              fl_req,
  output logic [1:0]                        fl_cmd,
  output logic [flash_prog_pkg::FLASH_AW-1:0] fl_addr,
  output logic [7:0]                        fl_wdata,
  // Boot vector and RAM loader
  output logic [15:0]                       boot_vector,
  output logic                              ram_wr_en,
  output logic [7:0]                        ram_wr_addr,
  output logic [7:0]                        ram_wr_data,
  output logic                              exec_from_ram,
  // Mode indications
  output logic                              in_circuit_comm_mode,
  output logic                              in_circuit_prog_mode,
  output logic                              in_app_prog_mode
);
  import flash_prog_pkg::*;

  localparam int PW = $clog2(PAGE_BYTES);
  localparam int CW = $clog2(PAGE_BYTES + 1);

  // ===================================================================
  // Helpers
  // Sector 0 grows in powers of two from the option field
  function automatic logic [FLASH_AW-1:0] s0_size(input logic [1:0] sz);
    return SECTOR0_MIN << sz;
  endfunction

  function automatic logic sector_ok(input logic [FLASH_AW-1:0] a,
                                     input logic [1:0] sz,
                                     input logic app);
    return (a >= s0_size(sz)) || !app;
  endfunction

  function automatic logic page_hit(input logic [7:0] idx);
    return int'(idx) >= int'(IDX_PAGE) &&
           int'(idx) < int'(IDX_PAGE) + PAGE_BYTES;
  endfunction

  function automatic logic reg_hit(input logic [7:0] idx);
    return idx == IDX_CTRL || idx == IDX_ADDR || idx == IDX_COUNT ||
           idx == IDX_STATUS || page_hit(idx);
  endfunction

  // ===================================================================
  // Pin synchronisers; stage 1 feeds only stage 2
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  logic rst_s1, rst_s2, rst_s3, tool_s1, tool_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {clk_s1, clk_s2, clk_s3, dat_s1, dat_s2} <= 5'h00;
      {rst_s1, rst_s2, rst_s3} <= 3'h7; // No false release edge
      {tool_s1, tool_s2} <= 2'h0;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {prog_link_clock, clk_s1, clk_s2};
      {dat_s1, dat_s2} <= {prog_link_data, dat_s1};
      {rst_s1, rst_s2, rst_s3} <= {reset_pin_n, rst_s1, rst_s2};
      {tool_s1, tool_s2} <= {tool_socket, tool_s1};
    end
  end

  logic link_rise;
  assign link_rise = clk_s2 && !clk_s3;

  // ===================================================================
  // Link receiver: entry key under reset, then length and RAM bytes
  rx_e         rx_q, rx_d;
  logic [7:0]  shift_q, shift_d, len_q, len_d, cnt_q, cnt_d;
  logic [2:0]  bits_q, bits_d;
  logic        armed_q, armed_d, comm_q, comm_d, exec_q, exec_d;
  logic        we_q, we_d;
  logic [7:0]  wa_q, wa_d, wd_q, wd_d;
  logic [15:0] vec_q, vec_d;
  logic [7:0]  shin;

  always_comb begin
    rx_d = rx_q; shift_d = shift_q; len_d = len_q; cnt_d = cnt_q;
    bits_d = bits_q; armed_d = armed_q; comm_d = comm_q;
    exec_d = exec_q; we_d = 1'b0; wa_d = wa_q; wd_d = wd_q;
    vec_d = vec_q;
    shin = {shift_q[6:0], dat_s2};
    if (!rst_s2) begin
      // Pin reset ends any session and listens for the key
      comm_d = 1'b0; exec_d = 1'b0; rx_d = RX_IDLE;
      if (link_rise) begin
        shift_d = shin;
        if (shin == ENTRY_KEY) armed_d = 1'b1;
      end
    end else if (!rst_s3) begin
      // Release: pick the boot vector the core will fetch
      comm_d = armed_q;
      armed_d = 1'b0;
      vec_d = armed_q ? SYS_VECTOR : APP_VECTOR;
      rx_d = armed_q ? RX_LEN : RX_IDLE;
      bits_d = 3'h0; cnt_d = 8'h00; shift_d = 8'h00;
    end else if (link_rise && (rx_q == RX_LEN || rx_q == RX_DATA)) begin
      shift_d = shin;
      bits_d = 3'(bits_q + 3'h1);
      if (bits_q == 3'h7) begin
        if (rx_q == RX_LEN) begin
          len_d = shin;
          rx_d = (shin == 8'h00) ? RX_RUN : RX_DATA;
          exec_d = (shin == 8'h00);
        end else begin
          we_d = 1'b1; wa_d = cnt_q; wd_d = shin;
          cnt_d = 8'(cnt_q + 8'h01);
          if (cnt_q == 8'(len_q - 8'h01)) begin
            rx_d = RX_RUN;
            exec_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= RX_IDLE; shift_q <= 8'h00; len_q <= 8'h00;
      cnt_q <= 8'h00; bits_q <= 3'h0; armed_q <= 1'b0;
      comm_q <= 1'b0; exec_q <= 1'b0; we_q <= 1'b0;
      wa_q <= 8'h00; wd_q <= 8'h00; vec_q <= APP_VECTOR;
    end else begin
      rx_q <= rx_d; shift_q <= shift_d; len_q <= len_d;
      cnt_q <= cnt_d; bits_q <= bits_d; armed_q <= armed_d;
      comm_q <= comm_d; exec_q <= exec_d; we_q <= we_d;
      wa_q <= wa_d; wd_q <= wd_d; vec_q <= vec_d;
    end
  end

  // ===================================================================
  // Bus slave, registers and program/erase engine
  logic              awr_q, awr_d, wr_q, wr_d, awh_q, awh_d, wh_q, wh_d;
  logic [7:0]        awi_q, awi_d;
  logic [31:0]       wdt_q, wdt_d, rdt_q, rdt_d;
  logic              ws0_q, ws0_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [1:0]        br_q, br_d, rr_q, rr_d;
  logic [1:0]        op_q, op_d;
  logic              opt_q, opt_d, ref_q, ref_d;
  logic [FLASH_AW-1:0] addr_q, addr_d;
  logic [CW-1:0]     count_q, count_d, n_q, n_d, n;
  logic [7:0]        page_q [PAGE_BYTES];
  logic [7:0]        page_d [PAGE_BYTES];
  eng_e              st_q, st_d;
  logic [PW-1:0]     idx_q, idx_d;
  logic              req_q, req_d, ack_now, ok, app_mode;
  logic [1:0]        cmd_q, cmd_d, s_op;
  logic [FLASH_AW-1:0] fa_q, fa_d;
  logic [7:0]        fd_q, fd_d, ri;
  logic [FLASH_AW:0] last_w;
  logic [1:0]        sz;
  mode_e             mode_q, mode_d;
  logic              circ_q, circ_d, app_q, app_d;

  assign sz = option_byte[OPT_S0 +: 2];
  assign ack_now = fl_ack && req_q;

  always_comb begin
    awr_d = awr_q; wr_d = wr_q; awh_d = awh_q; wh_d = wh_q;
    awi_d = awi_q; wdt_d = wdt_q; ws0_d = ws0_q; bv_d = bv_q;
    br_d = br_q; arr_d = arr_q; rv_d = rv_q; rr_d = rr_q;
    rdt_d = rdt_q; op_d = op_q; opt_d = opt_q; ref_d = ref_q;
    addr_d = addr_q; count_d = count_q; page_d = page_q;
    st_d = st_q; idx_d = idx_q; n_d = n_q; ok = 1'b0;
    s_op = wdt_q[CTRL_OP +: 2];
    n = (s_op == OP_PAGE) ? count_q : CW'(1);
    last_w = {1'b0, addr_q} + (FLASH_AW + 1)'(n) - (FLASH_AW + 1)'(1);
    app_mode = (mode_q == MODE_IN_APP);
    // Mode: tool strap first, then an entered comm session
    mode_d = tool_s2 ? MODE_TOOL : (comm_q ? MODE_IN_CIRCUIT : MODE_IN_APP);
    // Mode pins get their own flops so no decode sits on an output
    circ_d = (mode_d == MODE_IN_CIRCUIT);
    app_d = (mode_d == MODE_IN_APP);
    // Address and data are taken in either order
    if (s_axi_awvalid && awr_q) begin
      awh_d = 1'b1; awi_d = s_axi_awaddr[AXI_AW-1:2];
    end
    if (s_axi_wvalid && wr_q) begin
      wh_d = 1'b1; wdt_d = s_axi_wdata; ws0_d = s_axi_wstrb[0];
    end
    if (awh_q && wh_q && !bv_q) begin
      awh_d = 1'b0; wh_d = 1'b0; bv_d = 1'b1;
      br_d = reg_hit(awi_q) ? RESP_OKAY : RESP_SLVERR;
      // Writes while the engine runs only reach the refused flag
      if (ws0_q && st_q == S_IDLE) begin
        if (awi_q == IDX_ADDR) addr_d = wdt_q[FLASH_AW-1:0];
        if (awi_q == IDX_COUNT) count_d = wdt_q[CW-1:0];
        if (page_hit(awi_q))
          page_d[PW'(awi_q - IDX_PAGE)] = wdt_q[7:0];
      end
      if (ws0_q && awi_q == IDX_CTRL) begin
        if (wdt_q[CTRL_REFUSED]) ref_d = 1'b0;
        if (st_q == S_IDLE) begin
          op_d = s_op; opt_d = wdt_q[CTRL_OPT];
        end
        if (st_q == S_IDLE && wdt_q[CTRL_START]) begin
          ok = !option_byte[OPT_LOCK] && s_op != 2'h3 &&
               n != CW'(0) && int'(n) <= PAGE_BYTES;
          if (wdt_q[CTRL_OPT])
            ok = ok && !app_mode;
          else if (s_op == OP_ERASE)
            ok = ok && sector_ok(addr_q, sz, app_mode);
          else
            ok = ok && !last_w[FLASH_AW] &&
                 sector_ok(addr_q, sz, app_mode) &&
                 sector_ok(last_w[FLASH_AW-1:0], sz, app_mode);
          if (ok) begin
            idx_d = '0; n_d = n;
            // Unprotecting starts with a wipe of both sectors
            if (wdt_q[CTRL_OPT] && option_byte[OPT_RDP] &&
                (s_op == OP_ERASE || !page_q[0][OPT_RDP]))
              st_d = S_CLEAR0;
            else
              st_d = S_OP;
          end else begin
            ref_d = 1'b1; // Set wins over a clear in the same write
          end
        end
      end
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    awr_d = !awh_d && !bv_d;
    wr_d = !wh_d && !bv_d;
    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && arr_q) begin
      ri = s_axi_araddr[AXI_AW-1:2];
      rv_d = 1'b1;
      rr_d = reg_hit(ri) ? RESP_OKAY : RESP_SLVERR;
      rdt_d = 32'h0000_0000;
      if (ri == IDX_CTRL)
        rdt_d[5:0] = {ref_q, st_q != S_IDLE, opt_q, op_q, 1'b0};
      if (ri == IDX_ADDR) rdt_d[FLASH_AW-1:0] = addr_q;
      if (ri == IDX_COUNT) rdt_d[CW-1:0] = count_q;
      if (ri == IDX_STATUS)
        rdt_d[6:0] = {exec_q, comm_q, armed_q, option_byte[OPT_RDP],
                      option_byte[OPT_LOCK], mode_q};
      if (page_hit(ri)) rdt_d[7:0] = page_q[PW'(ri - IDX_PAGE)];
    end else begin
      ri = 8'h00;
    end
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    arr_d = !rv_d;
    // Engine steps advance on each flash acknowledge
    if (ack_now) begin
      unique case (st_q)
        S_CLEAR0: st_d = S_CLEAR1;
        S_CLEAR1: st_d = S_OP;
        S_OP: begin
          if (op_q == OP_ERASE || CW'(idx_q) == CW'(n_q - CW'(1)))
            st_d = S_IDLE;
          else
            idx_d = PW'(idx_q + PW'(1));
        end
        default: st_d = S_IDLE;
      endcase
    end
    // Payload holds steady while a request is raised
    cmd_d = FL_ERASE; fa_d = addr_q; fd_d = page_d[idx_d];
    unique case (st_d)
      S_CLEAR0: fa_d = '0;
      S_CLEAR1: fa_d = s0_size(sz);
      S_OP: begin
        if (op_d == OP_ERASE)
          cmd_d = opt_d ? FL_ERASE_OPT : FL_ERASE;
        else begin
          cmd_d = opt_d ? FL_PROG_OPT : FL_PROG;
          fa_d = addr_q + FLASH_AW'(idx_d);
        end
      end
      default: fa_d = addr_q;
    endcase
    // One idle cycle after each acknowledge separates requests
    req_d = (st_d != S_IDLE) && !ack_now;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_q <= 1'b1; wr_q <= 1'b1; awh_q <= 1'b0; wh_q <= 1'b0;
      awi_q <= 8'h00; wdt_q <= 32'h0000_0000; ws0_q <= 1'b0;
      bv_q <= 1'b0; br_q <= RESP_OKAY; arr_q <= 1'b1; rv_q <= 1'b0;
      rr_q <= RESP_OKAY; rdt_q <= 32'h0000_0000;
      {ref_q, opt_q, op_q} <= 4'(CTRL_RESET >> CTRL_OP);
      addr_q <= '0; count_q <= '0; st_q <= S_IDLE;
      idx_q <= '0; n_q <= '0; req_q <= 1'b0; cmd_q <= FL_PROG;
      fa_q <= '0; fd_q <= 8'h00; mode_q <= MODE_IN_APP;
      circ_q <= 1'b0; app_q <= 1'b1;
      for (int i = 0; i < PAGE_BYTES; i++) page_q[i] <= 8'h00;
    end else begin
      awr_q <= awr_d; wr_q <= wr_d; awh_q <= awh_d; wh_q <= wh_d;
      awi_q <= awi_d; wdt_q <= wdt_d; ws0_q <= ws0_d;
      bv_q <= bv_d; br_q <= br_d; arr_q <= arr_d; rv_q <= rv_d;
      rr_q <= rr_d; rdt_q <= rdt_d;
      ref_q <= ref_d; opt_q <= opt_d; op_q <= op_d;
      addr_q <= addr_d; count_q <= count_d; st_q <= st_d;
      idx_q <= idx_d; n_q <= n_d; req_q <= req_d; cmd_q <= cmd_d;
      fa_q <= fa_d; fd_q <= fd_d; mode_q <= mode_d;
      circ_q <= circ_d; app_q <= app_d;
      page_q <= page_d;
    end
  end

  // ===================================================================
  // Outputs, all straight from flip-flops
  assign s_axi_awready        = awr_q;
  assign s_axi_wready         = wr_q;
  assign s_axi_bvalid         = bv_q;
  assign s_axi_bresp          = br_q;
  assign s_axi_arready        = arr_q;
  assign s_axi_rvalid         = rv_q;
  assign s_axi_rresp          = rr_q;
  assign s_axi_rdata          = rdt_q;
  assign fl_req               = req_q;
  assign fl_cmd               = cmd_q;
  assign fl_addr              = fa_q;
  assign fl_wdata             = fd_q;
  assign boot_vector          = vec_q;
  assign ram_wr_en            = we_q;
  assign ram_wr_addr          = wa_q;
  assign ram_wr_data          = wd_q;
  assign exec_from_ram        = exec_q;
  assign in_circuit_comm_mode = comm_q;
  assign in_circuit_prog_mode = circ_q;
  assign in_app_prog_mode     = app_q;
endmodule
